// ===== pkg/bccd_pkg.sv
// Purpose: Shared constants and types for the bit-clear / branch executor
// Assumes: 32-bit Avalon-MM register window with byte addresses
// Notes:   Opcodes, bus offsets, field positions and phase codes
package bccd_pkg;

  // Register map (byte offsets)
  localparam logic [11:0] OFF_CTRL  = 12'h000;
  localparam logic [11:0] OFF_FLAGS = 12'h004;
  localparam logic [11:0] OFF_PGM   = 12'h008;
  localparam logic [11:0] OFF_IDX   = 12'h00c;
  localparam logic [11:0] OFF_INSTR = 12'h010;
  localparam logic [11:0] OFF_STAT  = 12'h014;
  localparam logic [11:0] OFF_ADDR  = 12'h018;
  localparam logic [11:0] OFF_CYC   = 12'h01c;
  localparam logic [1:0]  MEM_WIN   = 2'h1;

  // Field positions
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_BANK_LSB = 8;
  localparam int FLG_C  = 0;
  localparam int FLG_Z  = 1;
  localparam int FLG_OV = 2;
  localparam int FLG_N  = 3;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_TAKEN = 1;
  localparam int STAT_BAD   = 2;
  localparam int STAT_IDX   = 3;

  // Reset values
  localparam logic [3:0]  RST_BANK  = 4'h0;
  localparam logic [3:0]  RST_FLAGS = 4'h0;
  localparam logic [11:0] RST_IDX   = 12'h000;
  localparam logic [15:0] RST_INSTR = 16'h0000;

  // Opcodes
  localparam logic [3:0] BIT_CLEAR_FILE_OP         = 4'h9;
  localparam logic [7:0] BRANCH_ON_NEGATIVE_OP     = 8'he6;
  localparam logic [7:0] BRANCH_ON_NO_CARRY_OP     = 8'he3;
  localparam logic [7:0] BRANCH_ON_NON_NEGATIVE_OP = 8'he7;
  localparam logic [7:0] BRANCH_ON_NO_OVERFLOW_OP  = 8'he5;
  localparam logic [7:0] BRANCH_ON_NONZERO_OP      = 8'he1;

  // Addressing
  localparam logic [7:0] IDX_MAX     = 8'h5f;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;

  // Instruction cycle phases
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} bccd_st_t;

endpackage

// ===== pkg/bccd_dec_if.sv
// Purpose: Carrier between executor core and opcode decoder
// Assumes: Decoder is purely combinational
// Notes:   Core drives instruction context, decoder returns results
`timescale 1ns/1ps
interface bccd_dec_if;
  logic [15:0] instr;
  logic [3:0]  flags;
  logic        ext_en;
  logic [3:0]  bank;
  logic [11:0] idx_base;
  logic        is_clr;
  logic        is_br;
  logic        taken;
  logic        idx_mode;
  logic [2:0]  bit_sel;
  logic [11:0] eff_addr;
  logic [8:0]  disp;

  modport core (output instr, flags, ext_en, bank, idx_base,
                input  is_clr, is_br, taken, idx_mode, bit_sel,
                       eff_addr, disp);
  modport dec  (input  instr, flags, ext_en, bank, idx_base,
                output is_clr, is_br, taken, idx_mode, bit_sel,
                       eff_addr, disp);
endinterface

// ===== logic/bccd_decode.sv
// Purpose: Opcode decode, branch condition and file address resolution
// Assumes: Inputs held stable by the core while an instruction runs
// Notes:   Purely combinational
`timescale 1ns/1ps
module bccd_decode
  import bccd_pkg::*;
(
  bccd_dec_if.dec d
);

  wire logic [7:0]  op_hi;
  wire logic [7:0]  f_addr;
  wire logic        acc_sel;
  wire logic        is_neg_br;
  wire logic        is_nc_br;
  wire logic        is_nn_br;
  wire logic        is_nov_br;
  wire logic        is_nz_br;
  wire logic        cond_ok;
  wire logic [11:0] acc_addr;
  wire logic [11:0] bank_addr;
  wire logic [11:0] idx_addr;

  assign op_hi   = d.instr[15:8];
  assign f_addr  = d.instr[7:0];
  assign acc_sel = ~d.instr[8];

  assign d.is_clr  = (d.instr[15:12] == BIT_CLEAR_FILE_OP);
  assign d.bit_sel = d.instr[11:9];

  assign is_neg_br = (op_hi == BRANCH_ON_NEGATIVE_OP);
  assign is_nc_br  = (op_hi == BRANCH_ON_NO_CARRY_OP);
  assign is_nn_br  = (op_hi == BRANCH_ON_NON_NEGATIVE_OP);
  assign is_nov_br = (op_hi == BRANCH_ON_NO_OVERFLOW_OP);
  assign is_nz_br  = (op_hi == BRANCH_ON_NONZERO_OP);
  assign d.is_br   = is_neg_br | is_nc_br | is_nn_br | is_nov_br | is_nz_br;

  assign cond_ok = (is_neg_br &  d.flags[FLG_N])
                 | (is_nc_br  & ~d.flags[FLG_C])
                 | (is_nn_br  & ~d.flags[FLG_N])
                 | (is_nov_br & ~d.flags[FLG_OV])
                 | (is_nz_br  & ~d.flags[FLG_Z]);
  assign d.taken = cond_ok;

  // Offset already doubled, still signed
  assign d.disp = {d.instr[7:0], 1'b0};

  // Access bank splits at f = 80h between low RAM and the SFR page
  assign acc_addr  = {(f_addr[7] ? ACC_HI_BANK : ACC_LO_BANK), f_addr};
  assign bank_addr = {d.bank, f_addr};
  assign idx_addr  = d.idx_base + {4'h0, f_addr};
  assign d.idx_mode = d.ext_en & acc_sel & (f_addr <= IDX_MAX);
  assign d.eff_addr = d.idx_mode ? idx_addr
                    : (acc_sel ? acc_addr : bank_addr);

endmodule

// ===== logic/bccd_core.sv
// Purpose: Executes bit-clear and conditional branch instructions
// Assumes: Software loads context over Avalon-MM, then writes INSTR
// Notes:   One instruction cycle is four clocks, Q1 to Q4
`timescale 1ns/1ps
module bccd_core
  import bccd_pkg::*;
#(
  parameter int PGM_W   = 21,
  parameter int DMEM_AW = 8,
  parameter int CYC_W   = 16
)(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [11:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             exec_busy
);

  if (PGM_W < 10 || PGM_W > 32) begin : g_chk_pgm
    $error("PGM_W must lie in 10..32");
  end
  if (DMEM_AW < 1 || DMEM_AW > 8) begin : g_chk_mem
    $error("DMEM_AW must lie in 1..8");
  end
  if (CYC_W < 1 || CYC_W > 32) begin : g_chk_cyc
    $error("CYC_W must lie in 1..32");
  end

  localparam int DEPTH = 1 << DMEM_AW;

  //////////////////////////////////////////////////////////////////////////
  // State
  //////////////////////////////////////////////////////////////////////////

  bccd_st_t             st_r;
  bccd_st_t             st_nxt;
  logic [1:0]           ph_r;
  logic                 ext_en_r;
  logic [3:0]           bank_r;
  logic [3:0]           flags_r;
  logic [11:0]          idx_base_r;
  logic [15:0]          instr_r;
  logic [PGM_W-1:0]     pgm_ctr_r;
  logic [7:0]           data_r;
  logic [7:0]           res_r;
  logic [DMEM_AW-1:0]   wr_idx_r;
  logic [11:0]          last_addr_r;
  logic                 taken_r;
  logic                 bad_r;
  logic                 last_idx_r;
  logic [CYC_W-1:0]     cyc_cnt_r;
  logic                 rd_hold_r;
  logic [31:0]          rdata_r;
  logic [7:0]           dmem [0:DEPTH-1];

  bccd_dec_if dif ();

  bccd_decode u_dec (
    .d (dif.dec)
  );

  assign dif.instr    = instr_r;
  assign dif.flags    = flags_r;
  assign dif.ext_en   = ext_en_r;
  assign dif.bank     = bank_r;
  assign dif.idx_base = idx_base_r;

  //////////////////////////////////////////////////////////////////////////
  // Bus decode
  //////////////////////////////////////////////////////////////////////////

  wire logic             busy;
  wire logic             wr_go;
  wire logic             rd_go;
  wire logic             sel_ctrl;
  wire logic             sel_flags;
  wire logic             sel_pgm;
  wire logic             sel_idx;
  wire logic             sel_instr;
  wire logic             sel_stat;
  wire logic             sel_addr;
  wire logic             sel_cyc;
  wire logic             sel_mem;
  wire logic [7:0]       win_idx;
  wire logic [DMEM_AW-1:0] bus_midx;
  wire logic [31:0]      rd_mux;

  assign busy      = (st_r != ST_IDLE);
  assign exec_busy = busy;
  assign wr_go     = write & ~busy;
  assign rd_go     = read & ~busy & ~rd_hold_r;

  // Requests stall while an instruction runs; reads take one extra clock
  assign waitrequest = busy ? (read | write) : (read & ~rd_hold_r);

  assign sel_ctrl  = (address == OFF_CTRL);
  assign sel_flags = (address == OFF_FLAGS);
  assign sel_pgm   = (address == OFF_PGM);
  assign sel_idx   = (address == OFF_IDX);
  assign sel_instr = (address == OFF_INSTR);
  assign sel_stat  = (address == OFF_STAT);
  assign sel_addr  = (address == OFF_ADDR);
  assign sel_cyc   = (address == OFF_CYC);
  assign win_idx   = address[9:2];
  assign bus_midx  = win_idx[DMEM_AW-1:0];
  assign sel_mem   = (address[11:10] == MEM_WIN)
                   & ((32'(win_idx) >> DMEM_AW) == 32'h0000_0000);

  assign rd_mux =
      sel_ctrl  ? {20'h0_0000, bank_r, 7'h00, ext_en_r}
    : sel_flags ? {28'h000_0000, flags_r}
    : sel_pgm   ? 32'(pgm_ctr_r)
    : sel_idx   ? {20'h0_0000, idx_base_r}
    : sel_instr ? {16'h0000, instr_r}
    : sel_stat  ? {28'h000_0000, last_idx_r, bad_r, taken_r, busy}
    : sel_addr  ? {20'h0_0000, last_addr_r}
    : sel_cyc   ? 32'(cyc_cnt_r)
    : sel_mem   ? {24'h00_0000, dmem[bus_midx]}
    : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_hold_r <= 1'b0;
      rdata_r   <= 32'h0000_0000;
    end else begin
      rd_hold_r <= rd_go;
      if (rd_go) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign readdata = rdata_r;

  //////////////////////////////////////////////////////////////////////////
  // Software-owned context
  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ext_en_r   <= 1'b0;
      bank_r     <= RST_BANK;
      flags_r    <= RST_FLAGS;
      idx_base_r <= RST_IDX;
      instr_r    <= RST_INSTR;
    end else if (wr_go) begin
      if (sel_ctrl) begin
        ext_en_r <= writedata[CTRL_EXT_BIT];
        bank_r   <= writedata[CTRL_BANK_LSB +: 4];
      end
      // Flags change only by software, never by execution
      if (sel_flags) begin
        flags_r <= writedata[3:0];
      end
      if (sel_idx) begin
        idx_base_r <= writedata[11:0];
      end
      if (sel_instr) begin
        instr_r <= writedata[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Instruction cycle sequencer
  //////////////////////////////////////////////////////////////////////////

  wire logic at_q1;
  wire logic at_q2;
  wire logic at_q3;
  wire logic at_q4;
  wire logic br_jump;

  assign at_q1   = (st_r == ST_EXEC) & (ph_r == PH_Q1);
  assign at_q2   = (st_r == ST_EXEC) & (ph_r == PH_Q2);
  assign at_q3   = (st_r == ST_EXEC) & (ph_r == PH_Q3);
  assign at_q4   = (st_r == ST_EXEC) & (ph_r == PH_Q4);
  assign br_jump = dif.is_br & dif.taken;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (wr_go && sel_instr) begin
          st_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (ph_r == PH_Q4) begin
          st_nxt = br_jump ? ST_NOP : ST_IDLE;
        end
      end
      ST_NOP: begin
        if (ph_r == PH_Q4) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_r <= ST_IDLE;
      ph_r <= PH_Q1;
    end else begin
      st_r <= st_nxt;
      ph_r <= (st_r == ST_IDLE) ? PH_Q1 : ph_r + 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Program counter
  //////////////////////////////////////////////////////////////////////////

  wire logic [PGM_W-1:0] disp_ext;

  assign disp_ext = {{(PGM_W-9){dif.disp[8]}}, dif.disp};

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pgm_ctr_r <= '0;
    end else if (wr_go && sel_pgm) begin
      pgm_ctr_r <= {writedata[PGM_W-1:1], 1'b0};
    end else if (at_q1) begin
      pgm_ctr_r <= pgm_ctr_r + PGM_W'(2);
    end else if (at_q4 && br_jump) begin
      pgm_ctr_r <= pgm_ctr_r + disp_ext;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Data path and data memory
  //////////////////////////////////////////////////////////////////////////

  wire logic [DMEM_AW-1:0] ex_midx;
  wire logic [7:0]         clr_mask;

  assign ex_midx  = dif.eff_addr[DMEM_AW-1:0];
  assign clr_mask = ~(8'h01 << dif.bit_sel);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      data_r      <= 8'h00;
      res_r       <= 8'h00;
      wr_idx_r    <= '0;
      last_addr_r <= 12'h000;
      last_idx_r  <= 1'b0;
    end else begin
      if (at_q2 && dif.is_clr) begin
        data_r      <= dmem[ex_midx];
        wr_idx_r    <= ex_midx;
        last_addr_r <= dif.eff_addr;
        last_idx_r  <= dif.idx_mode;
      end
      if (at_q3) begin
        res_r <= data_r & clr_mask;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_go && sel_mem) begin
      dmem[bus_midx] <= writedata[7:0];
    end else if (at_q4 && dif.is_clr) begin
      dmem[wr_idx_r] <= res_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status and cycle count
  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      taken_r   <= 1'b0;
      bad_r     <= 1'b0;
      cyc_cnt_r <= '0;
    end else begin
      if (at_q4) begin
        taken_r <= br_jump;
        bad_r   <= ~(dif.is_clr | dif.is_br);
      end
      if (wr_go && sel_cyc) begin
        cyc_cnt_r <= '0;
      end else if (busy && ph_r == PH_Q4) begin
        cyc_cnt_r <= cyc_cnt_r + CYC_W'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  //////////////////////////////////////////////////////////////////////////

  bit_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (at_q4 && dif.is_clr)
      |-> (res_r[dif.bit_sel] == 1'b0)
          && ((res_r | ~clr_mask) == (data_r | ~clr_mask)))
    else $error("bit clear result wrong");

  bank_pick_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (busy && !dif.idx_mode)
      |-> (dif.eff_addr[11:8] == (instr_r[8] ? bank_r
          : (instr_r[7] ? ACC_HI_BANK : ACC_LO_BANK))))
    else $error("bank selection wrong");

  idx_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (at_q2 && dif.is_clr)
      |-> ##2 (last_idx_r == (ext_en_r && !instr_r[8]
               && instr_r[7:0] <= IDX_MAX))
          && (!last_idx_r
              || last_addr_r == idx_base_r + {4'h0, instr_r[7:0]}))
    else $error("indexed offset mode wrong");

  neg_branch_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (at_q4 && instr_r[15:8] == BRANCH_ON_NEGATIVE_OP)
      |=> (st_r == ST_NOP) == flags_r[FLG_N])
    else $error("negative branch decision wrong");

  nc_branch_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (at_q4 && instr_r[15:8] == BRANCH_ON_NO_CARRY_OP)
      |=> taken_r == !flags_r[FLG_C])
    else $error("no-carry branch decision wrong");

  nn_branch_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (at_q1 && instr_r[15:8] == BRANCH_ON_NON_NEGATIVE_OP
     && flags_r[FLG_N])
      |-> ##4 (st_r == ST_IDLE))
    else $error("non-negative branch decision wrong");

  nov_branch_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (at_q4 && instr_r[15:8] == BRANCH_ON_NO_OVERFLOW_OP)
      |-> br_jump == !flags_r[FLG_OV])
    else $error("no-overflow branch decision wrong");

  nz_branch_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (at_q1 && instr_r[15:8] == BRANCH_ON_NONZERO_OP && !flags_r[FLG_Z])
      |-> ##4 (st_r == ST_NOP))
    else $error("nonzero branch decision wrong");

  br_target_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (at_q1 && dif.is_br && dif.taken)
      |-> ##4 (pgm_ctr_r == $past(pgm_ctr_r, 4) + PGM_W'(2)
               + {{(PGM_W-9){instr_r[7]}}, instr_r[7:0], 1'b0}))
    else $error("branch target wrong");

  nop_cycle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (at_q4 && br_jump)
      |=> (st_r == ST_NOP) [*4] ##1 (st_r == ST_IDLE))
    else $error("taken branch length wrong");

  rmw_seq_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (at_q1 && dif.is_clr)
      |-> ##4 (st_r == ST_IDLE) && (dmem[wr_idx_r] == $past(res_r)))
    else $error("bit clear sequence wrong");

  flags_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    busy |=> $stable(flags_r))
    else $error("status flags changed by execution");

endmodule

// ===== dv/tb.sv
// Purpose: Self-checking bench for the bit-clear / branch executor
// Assumes: Register map and bus timing of the executor core
// Notes:   Reads are checked by a monitor against a queue of notes
`timescale 1ns/1ps
module tb
  import bccd_pkg::*;
;
  localparam int          PW = 21;
  localparam logic [31:0] PM = 32'h001f_fffe;

  typedef struct {
    logic [31:0] e;
    logic [31:0] m;
  } bccd_exp_t;

  logic        ref_clk;
  logic        rst_b;
  logic [11:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        exec_busy;
  bccd_exp_t   expq[$];
  bccd_exp_t   x;
  int          n_fail;
  int          n_checks;

  bccd_core #(.PGM_W(PW), .DMEM_AW(8), .CYC_W(16)) i_bccd_core (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .exec_busy   (exec_busy)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wait_ack;
    int c;
    c = 0;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) begin
      c++;
      if (c > 50) begin
        n_fail++;
        results();
      end
      @(posedge ref_clk);
    end
  endtask

  task bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    address   <= a;
    writedata <= d;
    write     <= 1'b1;
    wait_ack();
    write     <= 1'b0;
  endtask

  task bus_rd(input logic [11:0] a, input logic [31:0] e,
              input logic [31:0] m);
    expq.push_back('{e: e, m: m});
    @(posedge ref_clk);
    address <= a;
    read    <= 1'b1;
    wait_ack();
    read    <= 1'b0;
  endtask

  // Starts one instruction and counts the clocks it keeps the core busy
  task run(input logic [15:0] ins, input logic [31:0] ecyc);
    int c;
    c = 0;
    bus_wr(OFF_INSTR, {16'h0000, ins});
    #1;
    while (exec_busy === 1'b1 && c < 20) begin
      c++;
      @(posedge ref_clk);
      #1;
    end
    chk(32'(c), ecyc);
    // A core that never goes idle has already counted as a mismatch
    if (c >= 20)
      results();
  endtask

  // Read monitor: every answered read retires the oldest note
  always @(posedge ref_clk) begin
    if (rst_b && read && !waitrequest) begin
      if (expq.size() == 0) begin
        n_fail++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, readdata, 32'h0);
      end else begin
        x = expq.pop_front();
        chk(readdata & x.m, x.e);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  op_t[5]  = '{8'he6, 8'he3, 8'he7, 8'he5, 8'he1};
  int          fb_t[5]  = '{FLG_N, FLG_C, FLG_N, FLG_OV, FLG_Z};
  logic        tw_t[5]  = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic        ex_t[8]  = '{1'b0, 1'b0, 1'b0, 1'b1,
                            1'b1, 1'b1, 1'b0, 1'b1};
  logic        a_t[8]   = '{1'b1, 1'b0, 1'b0, 1'b0,
                            1'b0, 1'b1, 1'b0, 1'b0};
  logic [7:0]  f_t[8]   = '{8'h3c, 8'h7f, 8'h80, 8'h5f,
                            8'h60, 8'h10, 8'h00, 8'h00};

  initial begin
    logic [31:0] v;
    logic [31:0] pg;
    logic [31:0] tg;
    logic [11:0] ea;
    logic [11:0] ib;
    logic [3:0]  bk;
    logic [3:0]  fl;
    logic [7:0]  n;
    logic        ix;
    logic        tk;
    rst_b     = 1'b0;
    address   = 12'h000;
    read      = 1'b0;
    write     = 1'b0;
    writedata = 32'h0000_0000;
    n_fail    = 0;
    n_checks  = 0;
    void'($urandom(32'h57ff_ff6f));
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Reset values and unmapped space
    for (int i = 0; i < 8; i++)
      bus_rd(12'(i * 4), 32'h0000_0000, 32'hffff_ffff);
    bus_wr(12'h020, $urandom);
    bus_rd(12'h020, 32'h0000_0000, 32'hffff_ffff);
    // Bit clear over every bit position and addressing case
    ib = 12'($urandom);
    bus_wr(OFF_IDX, {20'h0_0000, ib});
    bus_rd(OFF_IDX, {20'h0_0000, ib}, 32'hffff_ffff);
    for (int k = 0; k < 8; k++) begin
      bk = 4'($urandom);
      fl = 4'($urandom);
      ix = ex_t[k] && !a_t[k] && (f_t[k] <= 8'h5f);
      if (ix)
        ea = ib + {4'h0, f_t[k]};
      else if (a_t[k])
        ea = {bk, f_t[k]};
      else
        ea = {(f_t[k] < 8'h80) ? 4'h0 : 4'hf, f_t[k]};
      v = {24'h00_0000, 8'($urandom)} | (32'h1 << k);
      bus_wr(OFF_CTRL, {20'h0_0000, bk, 7'h00, ex_t[k]});
      bus_wr(OFF_FLAGS, {28'h000_0000, fl});
      bus_wr(12'h400 + {2'h0, ea[7:0], 2'h0}, v);
      run({BIT_CLEAR_FILE_OP, 3'(k), a_t[k], f_t[k]}, 32'h4);
      bus_rd(12'h400 + {2'h0, ea[7:0], 2'h0},
             v & ~(32'h1 << k), 32'h0000_00ff);
      bus_rd(OFF_ADDR, {20'h0_0000, ea}, 32'h0000_0fff);
      bus_rd(OFF_CTRL, {20'h0_0000, bk, 7'h00, ex_t[k]},
             32'hffff_ffff);
      bus_rd(OFF_STAT, {28'h000_0000, ix, 3'h0},
             32'h0000_000d);
      bus_rd(OFF_FLAGS, {28'h000_0000, fl}, 32'h0000_000f);
    end
    // A request issued while busy is stalled until the cycle ends
    bus_wr(12'h480, $urandom);
    bus_wr(OFF_INSTR, {16'h0000, BIT_CLEAR_FILE_OP, 4'h1, 8'h20});
    bus_rd(OFF_STAT, 32'h0000_0000, 32'h0000_0001);
    bus_rd(OFF_INSTR, {16'h0000, BIT_CLEAR_FILE_OP, 4'h1, 8'h20},
           32'hffff_ffff);
    // Every conditional branch, taken and not taken
    for (int j = 0; j < 5; j++) begin
      for (int t = 0; t < 2; t++) begin
        tk = t[0];
        fl = 4'($urandom);
        fl[fb_t[j]] = tk ? tw_t[j] : ~tw_t[j];
        n = (j == 0) ? 8'h80 : (j == 1) ? 8'h7f : 8'($urandom);
        pg = $urandom & PM;
        tg = pg + 32'h2;
        if (tk)
          tg = tg + {{23{n[7]}}, n, 1'b0};
        bus_wr(OFF_PGM, pg);
        bus_wr(OFF_FLAGS, {28'h000_0000, fl});
        bus_wr(OFF_CYC, 32'h0000_0000);
        run({op_t[j], n}, tk ? 32'h8 : 32'h4);
        bus_rd(OFF_PGM, tg & PM, 32'hffff_ffff);
        bus_rd(OFF_STAT, {30'h0, tk, 1'b0}, 32'h0000_0006);
        bus_rd(OFF_FLAGS, {28'h000_0000, fl}, 32'h0000_000f);
        bus_rd(OFF_CYC, tk ? 32'h2 : 32'h1, 32'hffff_ffff);
      end
    end
    // Branch ops above through the same reads
    // Unhandled opcode: one plain cycle, flagged, no branch
    fl = 4'($urandom);
    bus_wr(OFF_FLAGS, {28'h000_0000, fl});
    run({4'h0, 12'($urandom)}, 32'h4);
    bus_rd(OFF_STAT, 32'h0000_0004, 32'h0000_0006);
    bus_rd(OFF_FLAGS, {28'h000_0000, fl}, 32'h0000_000f);
    repeat (2) @(posedge ref_clk);
    if (expq.size() != 0)
      n_fail++;
    results();
  end
endmodule
